// ---- gdf_fault_ctrl_regs.v ----
// Summary of operation
// [R1] Read-only 11-bit secondary fault status at address 0x01, zero after reset.
// [R2] Bits 10, 9, 8 flag sense overcurrent on phases A, B, C.
// [R3] Bit 6 flags gate supply undervoltage; bit 7 flags overtemperature warning.
// [R4] Bits 5 to 0 flag gate faults AH, AL, BH, BL, CH, CL.
// [R5] Read/write 11-bit driver control at address 0x02, zero after reset.
// [R6] Scope bit clear shuts affected half-bridge; set shuts all three.
// [R7] Bit 9 set disables the gate supply undervoltage fault.
// [R8] Bit 8 set disables gate drive fault detection.
// [R9] Bit 7 set reports overtemperature warning on fault pin and summary bit.
// [R10] Bits 6-5 select six, three, single or independent PWM input.
// [R11] Single-input mode: bit 4 picks synchronous or asynchronous rectification.
// [R12] Single-input mode: direction is bit 3 ORed with phase C high pin.
// [R13] Writing 1 to bit 2 puts every MOSFET in coast state.
// [R14] Writing 1 to bit 1 turns on all low-side MOSFETs.
// [R15] Single-input mode: brake bit ORed with phase C low pin.
// [R16] Writing 1 to bit 0 clears latched faults; bit self-clears.
// [R17] Summary fault is OR of fault bits and mirrors fault pin.
// [R18] Lock code 110b blocks writes except lock and control bits 0-2.
// [R19] Disabled fault sources neither latch nor reach summary or pin.
`timescale 1ns/1ps
`default_nettype none
`include "gdf_regs.vh"
module gdf_fault_ctrl_regs (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    input  wire [3:0]  i_addr,
    input  wire [10:0] i_wdata,
    output reg  [10:0] o_rdata,
    input  wire [2:0]  i_sense_overcurrent,
    input  wire [2:0]  i_drain_source_overcurrent,
    input  wire        i_overtemp_warning,
    input  wire        i_charge_pump_supply_uv,
    input  wire        i_low_side_gate_supply_uv,
    input  wire [5:0]  i_gate_fault,
    input  wire        i_other_fault,
    input  wire        i_phase_c_high_input,
    input  wire        i_phase_c_low_input,
    output wire        o_fault_out_n,
    output wire        o_summary_fault,
    output wire        o_locked,
    output wire [2:0]  o_bridge_shutdown,
    output wire        o_coast,
    output wire        o_brake,
    output wire        o_direction,
    output wire        o_async_rect,
    output wire [1:0]  o_pwm_mode
);
    reg  [10:0] ctrl_q;
    reg  [10:0] ctrl_d;
    reg  [2:0]  lock_q;
    reg  [2:0]  lock_d;
    reg         summary_q;
    wire [10:0] status_w;
    wire [10:0] event_w;
    wire [10:0] enable_w;
    wire        locked_w;
    wire        warn_w;
    wire        fault_any_w;
    wire        clear_w;

    function is_addr;
        input [3:0] a;
        input [3:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    assign locked_w = (lock_q == `GDF_LOCK_CODE);
    assign o_locked = locked_w;

    // Event order follows the status word layout
    assign event_w = {i_sense_overcurrent, i_overtemp_warning,
                      i_charge_pump_supply_uv | i_low_side_gate_supply_uv,
                      i_gate_fault}; // [R2] [R3] [R4]
    assign enable_w = {3'h7, 1'b1, ~ctrl_q[`GDF_DC_UV_DIS],
                       {6{~ctrl_q[`GDF_DC_GF_DIS]}}}; // [R7] [R8] [R19]

    // Clear acts on the write edge and is never stored, so bit 0 always reads 0
    assign clear_w = i_wr_en && is_addr(i_addr, `GDF_ADDR_DRV_CTRL)
                     && i_wdata[`GDF_DC_CLR]; // [R16]

    gdf_fault_latch u_latch (
        .i_mclk   (i_mclk),
        .i_reset  (i_reset),
        .i_event  (event_w),
        .i_enable (enable_w),
        .i_clear  (clear_w),
        .o_status (status_w)
    ); // [R1]

    // Warning latches for reading but reaches the pin only when reported
    assign warn_w = status_w[`GDF_FS_WARN] & ctrl_q[`GDF_DC_WARN_REP]; // [R9]
    assign fault_any_w = (|status_w[10:8]) | (|status_w[6:0]) | warn_w | i_other_fault;

    always @(posedge i_mclk) begin
        if (i_reset) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= fault_any_w; // [R17]
        end
    end
    assign o_summary_fault = summary_q; // [R17]
    assign o_fault_out_n   = ~summary_q; // [R17]

    always @* begin
        ctrl_d = ctrl_q;
        lock_d = lock_q;
        if (i_wr_en && is_addr(i_addr, `GDF_ADDR_DRV_CTRL)) begin
            if (locked_w) begin
                ctrl_d[2:0] = i_wdata[2:0]; // [R18]
            end else begin
                ctrl_d = i_wdata; // [R5]
            end
        end
        // Clear is a strobe only; a stored one would read back
        ctrl_d[`GDF_DC_CLR] = 1'b0; // [R16]
        if (i_wr_en && is_addr(i_addr, `GDF_ADDR_GATE_HS)) begin
            // Only the two codes change the lock field
            if (!locked_w && i_wdata[10:8] == `GDF_LOCK_CODE) begin
                lock_d = `GDF_LOCK_CODE; // [R18]
            end else if (locked_w && i_wdata[10:8] == `GDF_UNLOCK_CODE) begin
                lock_d = `GDF_UNLOCK_CODE; // [R18]
            end
        end
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            ctrl_q <= `GDF_DRV_CTRL_RESET;
            lock_q <= `GDF_LOCK_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            lock_q <= lock_d;
        end
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= 11'h000;
        end else if (i_rd_en) begin
            if (is_addr(i_addr, `GDF_ADDR_FAULT_SEC)) begin
                o_rdata <= status_w; // [R1]
            end else if (is_addr(i_addr, `GDF_ADDR_DRV_CTRL)) begin
                o_rdata <= ctrl_q;
            end else if (is_addr(i_addr, `GDF_ADDR_GATE_HS)) begin
                o_rdata <= {lock_q, 8'h00};
            end else begin
                o_rdata <= 11'h000;
            end
        end
    end

    gdf_bridge_ctrl u_bridge (
        .i_mclk               (i_mclk),
        .i_reset              (i_reset),
        .i_ctrl               (ctrl_q),
        .i_phase_c_high_input (i_phase_c_high_input),
        .i_phase_c_low_input  (i_phase_c_low_input),
        .i_overcurrent        (i_sense_overcurrent | i_drain_source_overcurrent),
        .o_bridge_shutdown    (o_bridge_shutdown),
        .o_coast              (o_coast),
        .o_brake              (o_brake),
        .o_direction          (o_direction),
        .o_async_rect         (o_async_rect),
        .o_pwm_mode           (o_pwm_mode)
    ); // [R6] [R10] [R13] [R14]
endmodule // gdf_fault_ctrl_regs
`default_nettype wire

// ---- gdf_regs.vh ----
`ifndef GDF_REGS_VH
`define GDF_REGS_VH
// Register addresses on the serial control port
`define GDF_ADDR_FAULT_SEC    4'h1
`define GDF_ADDR_DRV_CTRL     4'h2
`define GDF_ADDR_GATE_HS      4'h3
// Reset values
`define GDF_FAULT_SEC_RESET   11'h000
`define GDF_DRV_CTRL_RESET    11'h000
`define GDF_LOCK_RESET        3'h3
// Lock codes
`define GDF_LOCK_CODE         3'h6
`define GDF_UNLOCK_CODE       3'h3
// Status field positions
`define GDF_FS_OC_A           10
`define GDF_FS_OC_B           9
`define GDF_FS_OC_C           8
`define GDF_FS_WARN           7
`define GDF_FS_SUPPLY_UV      6
// Driver control field positions
`define GDF_DC_OCP_SCOPE      10
`define GDF_DC_UV_DIS         9
`define GDF_DC_GF_DIS         8
`define GDF_DC_WARN_REP       7
`define GDF_DC_MODE_HI        6
`define GDF_DC_MODE_LO        5
`define GDF_DC_RECT           4
`define GDF_DC_DIR            3
`define GDF_DC_COAST          2
`define GDF_DC_BRAKE          1
`define GDF_DC_CLR            0
// PWM input modes
`define GDF_MODE_SIX          2'h0
`define GDF_MODE_THREE        2'h1
`define GDF_MODE_SINGLE       2'h2
`define GDF_MODE_INDEP        2'h3
`endif

// ---- gdf_fault_latch.v ----
`timescale 1ns/1ps
`default_nettype none
module gdf_fault_latch (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire [10:0] i_event,
    input  wire [10:0] i_enable,
    input  wire        i_clear,
    output wire [10:0] o_status
);
    reg [10:0] status_q;
    genvar g;
    generate
        for (g = 0; g < 11; g = g + 1) begin : g_bit
            // Set wins over a clear in the same cycle
            always @(posedge i_mclk) begin
                if (i_reset) begin
                    status_q[g] <= 1'b0;
                end else if (i_event[g] && i_enable[g]) begin
                    status_q[g] <= 1'b1; // [R19]
                end else if (i_clear) begin
                    status_q[g] <= 1'b0; // [R16]
                end
            end
        end
    endgenerate
    assign o_status = status_q;
endmodule // gdf_fault_latch
`default_nettype wire

// ---- gdf_bridge_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "gdf_regs.vh"
module gdf_bridge_ctrl (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire [10:0] i_ctrl,
    input  wire        i_phase_c_high_input,
    input  wire        i_phase_c_low_input,
    input  wire [2:0]  i_overcurrent,
    output reg  [2:0]  o_bridge_shutdown,
    output reg         o_coast,
    output reg         o_brake,
    output reg         o_direction,
    output reg         o_async_rect,
    output reg  [1:0]  o_pwm_mode
);
    wire single_w = (i_ctrl[`GDF_DC_MODE_HI:`GDF_DC_MODE_LO] == `GDF_MODE_SINGLE);
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_bridge_shutdown <= 3'h0;
            o_coast           <= 1'b0;
            o_brake           <= 1'b0;
            o_direction       <= 1'b0;
            o_async_rect      <= 1'b0;
            o_pwm_mode        <= 2'h0;
        end else begin
            if (i_ctrl[`GDF_DC_OCP_SCOPE]) begin
                o_bridge_shutdown <= {3{|i_overcurrent}}; // [R6]
            end else begin
                o_bridge_shutdown <= i_overcurrent; // [R6]
            end
            o_pwm_mode   <= i_ctrl[`GDF_DC_MODE_HI:`GDF_DC_MODE_LO]; // [R10]
            o_coast      <= i_ctrl[`GDF_DC_COAST]; // [R13]
            o_async_rect <= single_w & i_ctrl[`GDF_DC_RECT]; // [R11]
            o_direction  <= single_w & (i_ctrl[`GDF_DC_DIR] | i_phase_c_high_input); // [R12]
            // The phase C low pin acts as brake only in single-input mode
            o_brake <= i_ctrl[`GDF_DC_BRAKE] | (single_w & i_phase_c_low_input); // [R14] [R15]
        end
    end
endmodule // gdf_bridge_ctrl
`default_nettype wire

// ---- gdf_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdf_checker (
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [3:0]  i_addr,
    input wire logic [10:0] i_wdata,
    input wire logic [10:0] o_rdata,
    input wire logic [2:0]  i_sense_overcurrent,
    input wire logic [2:0]  o_bridge_shutdown,
    input wire logic        o_fault_out_n,
    input wire logic        o_summary_fault,
    input wire logic        o_locked,
    input wire logic        o_coast,
    input wire logic        o_brake,
    input wire logic        o_direction,
    input wire logic [1:0]  o_pwm_mode
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence ctrl_wr;
        i_wr_en && i_addr == 4'h2;
    endsequence
    summary_mirror_a: assert property (o_summary_fault == !o_fault_out_n)
        else $error("summary bit and fault pin disagree");
    coast_set_a: assert property (ctrl_wr ##0 i_wdata[2] |-> ##2 o_coast)
        else $error("coast not applied");
    brake_set_a: assert property (ctrl_wr ##0 i_wdata[1] |-> ##2 o_brake)
        else $error("brake not applied");
    mode_sel_a: assert property (
        ctrl_wr ##0 !o_locked |-> ##2 o_pwm_mode == $past(i_wdata[6:5], 2))
        else $error("input mode differs from written field");
    clear_self_a: assert property (i_rd_en && i_addr == 4'h2 |=> !o_rdata[0])
        else $error("clear bit read back as one");
    oc_shut_a: assert property (|i_sense_overcurrent |-> ##[1:2] |o_bridge_shutdown)
        else $error("overcurrent without shutdown");
    dir_mode_a: assert property (o_direction |-> o_pwm_mode == 2'h2)
        else $error("direction outside single-input mode");
    lock_hold_a: assert property (ctrl_wr ##0 o_locked |-> ##2 $stable(o_pwm_mode))
        else $error("locked write changed input mode");
endmodule // gdf_checker
bind gdf_fault_ctrl_regs gdf_checker u_checker (
    .i_mclk              (i_mclk),
    .i_reset             (i_reset),
    .i_wr_en             (i_wr_en),
    .i_rd_en             (i_rd_en),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .o_rdata             (o_rdata),
    .i_sense_overcurrent (i_sense_overcurrent),
    .o_bridge_shutdown   (o_bridge_shutdown),
    .o_fault_out_n       (o_fault_out_n),
    .o_summary_fault     (o_summary_fault),
    .o_locked            (o_locked),
    .o_coast             (o_coast),
    .o_brake             (o_brake),
    .o_direction         (o_direction),
    .o_pwm_mode          (o_pwm_mode)
);
`default_nettype wire

// ---- gdf_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdf_host (
    input  wire logic        i_mclk,
    input  wire logic [10:0] i_rdata,
    output logic             o_wr_en,
    output logic             o_rd_en,
    output logic [3:0]       o_addr,
    output logic [10:0]      o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 4'h0;
        o_wdata = 11'h000;
    end
    // One-cycle strobe; data scrambled afterwards so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(negedge i_mclk);
        o_wr_en = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [10:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_rd_en = 1'b1;
        @(negedge i_mclk);
        o_rd_en = 1'b0;
        @(negedge i_mclk);
        d = i_rdata;
    endtask
endmodule // gdf_host
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_mclk = 0, i_reset = 1, warn = 0, cpuv = 0, lsuv = 0, ch = 0, cl = 0, oth = 0;
    logic wr, rd, fo_n, sum, lk, co, br, dir, asy;
    logic [3:0] addr;
    logic [10:0] wd, rdat, v;
    logic [2:0] soc = 3'h0, doc = 3'h0, shut;
    logic [5:0] gf = 6'h00;
    logic [1:0] mode;
    integer failures = 0, checked = 0;
    always #5 i_mclk = ~i_mclk;
    gdf_host host (.i_mclk(i_mclk), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr),
        .o_wdata(wd));
    gdf_fault_ctrl_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_wr_en(wr), .i_rd_en(rd),
        .i_addr(addr), .i_wdata(wd), .o_rdata(rdat), .i_sense_overcurrent(soc),
        .i_drain_source_overcurrent(doc), .i_overtemp_warning(warn),
        .i_charge_pump_supply_uv(cpuv), .i_low_side_gate_supply_uv(lsuv), .i_gate_fault(gf),
        .i_other_fault(oth), .i_phase_c_high_input(ch), .i_phase_c_low_input(cl),
        .o_fault_out_n(fo_n), .o_summary_fault(sum), .o_locked(lk), .o_bridge_shutdown(shut),
        .o_coast(co), .o_brake(br), .o_direction(dir), .o_async_rect(asy), .o_pwm_mode(mode));
    task stop_test;
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [10:0] g, input logic [10:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task rc(input logic [3:0] a, input logic [10:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    task wt(input integer n);
        repeat (n) @(negedge i_mclk);
    endtask
    // Watchdog bounds the whole run
    // Watchdog bounds the whole run
    initial begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        stop_test;
    end
    initial begin
        wt(20);
        i_reset = 1'b0;
        rc(4'h1, 11'h000);
        rc(4'h2, 11'h000);
        rc(4'h5, 11'h000);
        rc(4'h3, 11'h300);
        host.wr(4'h1, 11'h7FF);
        rc(4'h1, 11'h000);
        host.wr(4'h3, 11'h500);
        rc(4'h3, 11'h300);
        host.wr(4'h2, 11'h7FE);
        rc(4'h2, 11'h7FE);
        chk({co, br, mode}, 11'h00F);
        for (int m = 0; m < 4; m++) begin
            host.wr(4'h2, 11'(m << 5));
            wt(2);
            chk(mode, 11'(m));
        end
        host.wr(4'h2, 11'h000);
        {soc, gf, warn, cpuv} = {3'h4, 6'h21, 2'h3};
        wt(1);
        {soc, gf, warn, cpuv} = 11'h000;
        wt(3);
        rc(4'h1, 11'h4E1);
        chk({fo_n, sum}, 11'h001);
        host.wr(4'h2, 11'h001);
        rc(4'h1, 11'h000);
        rc(4'h2, 11'h000);
        chk({fo_n, sum}, 11'h002);
        oth = 1'b1;
        wt(2);
        chk({fo_n, sum}, 11'h001);
        oth = 1'b0;
        wt(2);
        warn = 1'b1;
        wt(1);
        warn = 1'b0;
        wt(3);
        rc(4'h1, 11'h080);
        chk(sum, 0);
        host.wr(4'h2, 11'h080);
        wt(2);
        chk(sum, 1);
        // Event and clear in one cycle: the event must win
        warn = 1'b1;
        host.wr(4'h2, 11'h081);
        warn = 1'b0;
        rc(4'h1, 11'h080);
        host.wr(4'h2, 11'h381);
        {lsuv, gf} = 7'h7F;
        wt(1);
        {lsuv, gf} = 7'h00;
        wt(3);
        rc(4'h1, 11'h000);
        chk(sum, 0);
        soc = 3'h2;
        wt(2);
        chk(shut, 11'h002);
        host.wr(4'h2, 11'h700);
        wt(2);
        chk(shut, 11'h007);
        {soc, doc} = 6'h01;
        wt(2);
        chk(shut, 11'h007);
        doc = 3'h0;
        host.wr(4'h2, 11'h040);
        {ch, cl} = 2'h3;
        wt(2);
        chk({dir, br, asy}, 11'h006);
        {ch, cl} = 2'h0;
        host.wr(4'h2, 11'h058);
        wt(2);
        chk({dir, br, asy}, 11'h005);
        host.wr(4'h3, 11'h600);
        chk(lk, 1);
        rc(4'h3, 11'h600);
        host.wr(4'h2, 11'h7FE);
        rc(4'h2, 11'h05E);
        host.wr(4'h3, 11'h500);
        chk(lk, 1);
        host.wr(4'h3, 11'h300);
        chk(lk, 0);
        host.wr(4'h2, 11'h000);
        rc(4'h2, 11'h000);
        // Mid-run reset with a latched fault and the lock set
        host.wr(4'h3, 11'h600);
        i_reset = 1'b1;
        wt(2);
        i_reset = 1'b0;
        rc(4'h1, 11'h000);
        rc(4'h3, 11'h300);
        chk({lk, fo_n, sum}, 11'h002);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
